// ==== pkg/mwt_pkg.sv ====
// mwt_pkg: constants for the monitor warning threshold bank
// assumes one system clock; serial management bus pins sampled on it
`default_nettype none
package mwt_pkg;

    // serial management address of the threshold space
    localparam logic [6:0] DEV_ADDR      = 7'h51;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [7:0] LIMIT_RST     = 8'h00;
    localparam logic [7:0] RD_UNMAPPED   = 8'h00;

    // threshold register indices into the limit array
    localparam int NUM_LIMITS    = 10;
    localparam int IDX_VMAX_HI   = 0;
    localparam int IDX_VMAX_LO   = 1;
    localparam int IDX_VMIN_HI   = 2;
    localparam int IDX_VMIN_LO   = 3;
    localparam int IDX_BMAX_HI   = 4;
    localparam int IDX_BMAX_LO   = 5;
    localparam int IDX_BMIN_HI   = 6;
    localparam int IDX_BMIN_LO   = 7;
    localparam int IDX_TXMAX_HI  = 8;
    localparam int IDX_TXMAX_LO  = 9;

    // byte addresses, same order as the indices above
    localparam logic [7:0] LIMIT_OFS [NUM_LIMITS] = '{
        8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h14,
        8'h15, 8'h16, 8'h17, 8'h1c, 8'h1d
    };

    // read-only warning status byte
    localparam logic [7:0] OFS_STATUS = 8'h74;
    localparam int ST_VMAX  = 0;
    localparam int ST_VMIN  = 1;
    localparam int ST_BMAX  = 2;
    localparam int ST_BMIN  = 3;
    localparam int ST_TXMAX = 4;
    localparam int ST_W     = 5;

    // count weights of the sixteen-bit threshold halves
    localparam real VOLT_HI_LSB_MV = 25.6;
    localparam real VOLT_LO_LSB_UV = 100.0;
    localparam real BIAS_LO_LSB_UA = 2.0;

    // serial engine states
    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
        ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_MACK
    } mwt_state_e;

endpackage
`default_nettype wire

// ==== core/mwt_line_watch.sv ====
// mwt_line_watch: start, stop and clock edge detection on the serial pins
// assumes scl and sda are already synchronous to clk_sys
`timescale 1ns/1ps
`default_nettype none
module mwt_line_watch
    import mwt_pkg::*;
(
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_n,
    // serial lines
    input  wire logic scl_in,
    input  wire logic sda_in,
    // decoded events
    output logic      scl_rise,
    output logic      scl_fall,
    output logic      start_seen,
    output logic      stop_seen
);

    logic scl_q;
    logic scl_d;
    logic sda_q;
    logic sda_d;

    // idle bus is high, so reset to high avoids a false edge
    always_comb begin
        scl_d = scl_in;
        sda_d = sda_in;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_d;
            sda_q <= sda_d;
        end
    end

    // sda moving while scl stays high marks a frame boundary
    assign scl_rise   = scl_in & ~scl_q;
    assign scl_fall   = ~scl_in & scl_q;
    assign start_seen = scl_in & scl_q & sda_q & ~sda_in;
    assign stop_seen  = scl_in & scl_q & ~sda_q & sda_in;

endmodule
`default_nettype wire

// ==== core/mwt_limit_cmp.sv ====
// mwt_limit_cmp: high and low warning compare for one measurement
// assumes sample_upd pulses once per fresh measurement high byte
`timescale 1ns/1ps
`default_nettype none
module mwt_limit_cmp
    import mwt_pkg::*;
#(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    // measurement and limits, high bytes only
    input  wire logic         sample_upd,
    input  wire logic [W-1:0] sample_hi,
    input  wire logic [W-1:0] max_hi,
    input  wire logic [W-1:0] min_hi,
    // warnings
    output logic              over_warn,
    output logic              under_warn
);

    logic over_d;
    logic under_d;

    // raw unsigned compare; low bytes never reach here
    always_comb begin
        over_d  = over_warn;
        under_d = under_warn;
        if (sample_upd) begin
            over_d  = sample_hi > max_hi;
            under_d = sample_hi < min_hi;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            over_warn  <= 1'b0;
            under_warn <= 1'b0;
        end else begin
            over_warn  <= over_d;
            under_warn <= under_d;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_over_crossing: assert property (
        sample_upd && sample_hi > max_hi |=> over_warn)
        else $error("over warning missed");
    a_under_crossing: assert property (
        sample_upd && sample_hi < min_hi |=> under_warn)
        else $error("under warning missed");
    // each edge on its own, so a single limit hit is enough to test it
    a_equal_no_over: assert property (
        sample_upd && sample_hi == max_hi |=> !over_warn)
        else $error("equal value raised an over warning");
    a_equal_no_under: assert property (
        sample_upd && sample_hi == min_hi |=> !under_warn)
        else $error("equal value raised an under warning");
    a_flag_hold: assert property (
        !sample_upd |=> $stable(over_warn) && $stable(under_warn))
        else $error("warning moved without a sample");

endmodule
`default_nettype wire

// ==== core/mwt_bank.sv ====
// mwt_bank: threshold registers behind the serial management slave
// assumes pins synchronous to clk_sys; sda is open drain
`timescale 1ns/1ps
`default_nettype none
module mwt_bank
    import mwt_pkg::*;
(
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    // serial management pins
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    // measurement high bytes with update strobes
    input  wire logic       supply_sample_upd,
    input  wire logic [7:0] supply_sample_hi,
    input  wire logic       bias_sample_upd,
    input  wire logic [7:0] bias_sample_hi,
    input  wire logic       tx_sample_upd,
    input  wire logic [7:0] tx_sample_hi,
    // warnings
    output logic            volt_high_warn,
    output logic            volt_low_warn,
    output logic            bias_high_warn,
    output logic            bias_low_warn,
    output logic            tx_high_warn
);

    logic             scl_rise;
    logic             scl_fall;
    logic             start_seen;
    logic             stop_seen;
    mwt_state_e       state_q;
    mwt_state_e       state_d;
    logic [3:0]       cnt_q;
    logic [3:0]       cnt_d;
    logic [7:0]       sh_q;
    logic [7:0]       sh_d;
    logic [7:0]       ptr_q;
    logic [7:0]       ptr_d;
    logic             rw_q;
    logic             rw_d;
    logic             nack_q;
    logic             nack_d;
    logic             oe_d;
    logic             wr_en;
    logic [7:0]       rd_data;
    logic [ST_W-1:0]  status;
    logic [7:0]       lim_q [NUM_LIMITS];
    logic [7:0]       lim_d [NUM_LIMITS];

    // true when the pointer selects the given byte address
    function automatic logic addr_hit(input logic [7:0] p,
                                      input logic [7:0] ofs);
        return p == ofs;
    endfunction

    mwt_line_watch u_watch (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .scl_in     (scl_in),
        .sda_in     (sda_in),
        .scl_rise   (scl_rise),
        .scl_fall   (scl_fall),
        .start_seen (start_seen),
        .stop_seen  (stop_seen)
    );

    // voltage pair: only high bytes feed the compare
    mwt_limit_cmp #(.W(8)) u_volt (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .sample_upd (supply_sample_upd),
        .sample_hi  (supply_sample_hi),
        .max_hi     (lim_q[IDX_VMAX_HI]),
        .min_hi     (lim_q[IDX_VMIN_HI]),
        .over_warn  (volt_high_warn),
        .under_warn (volt_low_warn)
    );

    mwt_limit_cmp #(.W(8)) u_bias (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .sample_upd (bias_sample_upd),
        .sample_hi  (bias_sample_hi),
        .max_hi     (lim_q[IDX_BMAX_HI]),
        .min_hi     (lim_q[IDX_BMIN_HI]),
        .over_warn  (bias_high_warn),
        .under_warn (bias_low_warn)
    );

    // tx has no low limit here; a zero floor can never be undercut
    mwt_limit_cmp #(.W(8)) u_tx (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .sample_upd (tx_sample_upd),
        .sample_hi  (tx_sample_hi),
        .max_hi     (lim_q[IDX_TXMAX_HI]),
        .min_hi     (LIMIT_RST),
        .over_warn  (tx_high_warn),
        .under_warn ()
    );

    // status byte mirrors the live warning flops
    always_comb begin
        status           = '0;
        status[ST_VMAX]  = volt_high_warn;
        status[ST_VMIN]  = volt_low_warn;
        status[ST_BMAX]  = bias_high_warn;
        status[ST_BMIN]  = bias_low_warn;
        status[ST_TXMAX] = tx_high_warn;
    end

    // read mux; low bytes read back as stored
    always_comb begin
        rd_data = RD_UNMAPPED;
        for (int i = 0; i < NUM_LIMITS; i++) begin
            if (addr_hit(ptr_q, LIMIT_OFS[i])) begin
                rd_data = lim_q[i];
            end
        end
        if (addr_hit(ptr_q, OFS_STATUS)) begin
            rd_data = {{(8 - ST_W){1'b0}}, status};
        end
    end

    // register writes; only the high byte of each hi/lo pair feeds a compare
    always_comb begin
        for (int i = 0; i < NUM_LIMITS; i++) begin
            lim_d[i] = lim_q[i];
            if (wr_en && addr_hit(ptr_q, LIMIT_OFS[i])) begin
                lim_d[i] = sh_q;
            end
        end
    end

    // serial slave: address, then pointer and write bytes, or read bytes at the current pointer
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        sh_d    = sh_q;
        ptr_d   = ptr_q;
        rw_d    = rw_q;
        nack_d  = nack_q;
        oe_d    = sda_oe;
        wr_en   = 1'b0;
        if (stop_seen) begin
            state_d = ST_IDLE;
            oe_d    = 1'b0;
        end else if (start_seen) begin
            // repeated start also lands here
            state_d = ST_ADDR;
            cnt_d   = '0;
            oe_d    = 1'b0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    oe_d = 1'b0;
                end
                ST_ADDR, ST_PTR, ST_WDATA: begin
                    if (scl_rise && cnt_q < BITS_PER_BYTE) begin
                        sh_d  = {sh_q[6:0], sda_in};
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == BITS_PER_BYTE) begin
                        cnt_d = '0;
                        if (state_q == ST_ADDR) begin
                            if (sh_q[7:1] == DEV_ADDR) begin
                                rw_d    = sh_q[0];
                                oe_d    = 1'b1;
                                state_d = ST_ADDR_ACK;
                            end else begin
                                // other devices on the bus: stay quiet
                                state_d = ST_IDLE;
                            end
                        end else if (state_q == ST_PTR) begin
                            ptr_d   = sh_q;
                            oe_d    = 1'b1;
                            state_d = ST_PTR_ACK;
                        end else begin
                            wr_en   = 1'b1;
                            ptr_d   = ptr_q + 8'h01;
                            oe_d    = 1'b1;
                            state_d = ST_WDATA_ACK;
                        end
                    end
                end
                ST_ADDR_ACK, ST_PTR_ACK, ST_WDATA_ACK: begin
                    if (scl_fall) begin
                        oe_d = 1'b0;
                        if (state_q == ST_ADDR_ACK && rw_q) begin
                            sh_d    = rd_data;
                            ptr_d   = ptr_q + 8'h01;
                            oe_d    = ~rd_data[7];
                            state_d = ST_RDATA;
                        end else if (state_q == ST_ADDR_ACK) begin
                            state_d = ST_PTR;
                        end else begin
                            state_d = ST_WDATA;
                        end
                    end
                end
                ST_RDATA: begin
                    if (scl_rise && cnt_q < BITS_PER_BYTE) begin
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == BITS_PER_BYTE) begin
                        cnt_d   = '0;
                        oe_d    = 1'b0;
                        state_d = ST_MACK;
                    end else if (scl_fall) begin
                        sh_d = {sh_q[6:0], 1'b0};
                        oe_d = ~sh_q[6];
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        nack_d = sda_in;
                    end else if (scl_fall && nack_q) begin
                        state_d = ST_IDLE;
                    end else if (scl_fall) begin
                        sh_d    = rd_data;
                        ptr_d   = ptr_q + 8'h01;
                        oe_d    = ~rd_data[7];
                        state_d = ST_RDATA;
                    end
                end
            endcase
        end
    end

    // sda only ever pulls low; the pin level comes from sda_oe
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            cnt_q   <= '0;
            sh_q    <= '0;
            ptr_q   <= '0;
            rw_q    <= 1'b0;
            nack_q  <= 1'b0;
            sda_oe  <= 1'b0;
            sda_out <= 1'b0;
            for (int i = 0; i < NUM_LIMITS; i++) begin
                lim_q[i] <= LIMIT_RST;
            end
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            sh_q    <= sh_d;
            ptr_q   <= ptr_d;
            rw_q    <= rw_d;
            nack_q  <= nack_d;
            sda_oe  <= oe_d;
            sda_out <= 1'b0;
            for (int i = 0; i < NUM_LIMITS; i++) begin
                lim_q[i] <= lim_d[i];
            end
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence s_addr_done;
        !stop_seen && !start_seen && state_q == ST_ADDR
        && scl_fall && cnt_q == BITS_PER_BYTE;
    endsequence

    sequence s_lo_write;
        !stop_seen && !start_seen && state_q == ST_WDATA && scl_fall
        && cnt_q == BITS_PER_BYTE && ptr_q == LIMIT_OFS[IDX_VMIN_LO];
    endsequence

    a_addr_match_ack: assert property (
        s_addr_done and (sh_q[7:1] == DEV_ADDR)
        |=> sda_oe && state_q == ST_ADDR_ACK)
        else $error("own address not acknowledged");
    a_addr_miss_quiet: assert property (
        s_addr_done and (sh_q[7:1] != DEV_ADDR)
        |=> !sda_oe && state_q == ST_IDLE)
        else $error("foreign address answered");
    a_lo_byte_kept: assert property (
        s_lo_write |=> lim_q[IDX_VMIN_LO] == $past(sh_q))
        else $error("low byte write not stored");
    a_lo_no_effect: assert property (
        s_lo_write and !supply_sample_upd
        |=> $stable(volt_low_warn) && $stable(volt_high_warn))
        else $error("low byte write moved a warning");

endmodule
`default_nettype wire

// ==== verification/mwt_host.sv ====
// mwt_host: behavioural two-wire bus master for the threshold bank
// assumes a pull-up on sda and scl phases timed in clk_sys cycles
`timescale 1ns/1ps
`default_nettype none
module mwt_host
    import mwt_pkg::*;
(
    // clock
    input  wire logic clk_sys,
    // serial lines
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_pull
);
    // bus released at time zero
    initial begin
        scl_out  = 1'b1;
        sda_pull = 1'b0;
    end

    // wait n edges, then move just after the last one
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // start or repeated start: sda falls while scl is high
    task automatic start();
        sda_pull = 1'b0;
        tick(2);
        scl_out = 1'b1;
        tick(3);
        sda_pull = 1'b1;
        tick(3);
        scl_out = 1'b0;
        tick(2);
    endtask

    // stop: sda rises while scl is high
    task automatic stop();
        sda_pull = 1'b1;
        tick(2);
        scl_out = 1'b1;
        tick(3);
        sda_pull = 1'b0;
        tick(3);
    endtask

    // data only moves in the low phase, else it would frame a start or stop
    task automatic bit_io(input logic b, output logic s);
        sda_pull = ~b;
        tick(2);
        scl_out = 1'b1;
        tick(2);
        s = sda_in;
        tick(2);
        scl_out = 1'b0;
        tick(2);
    endtask

    // one byte out, msb first, then the slave acknowledge bit
    task automatic send(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], s);
        bit_io(1'b1, s);
        ack = ~s;
    endtask

    // one byte in; last releases sda so the slave stops sending
    task automatic recv(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, b[i]);
        bit_io(last, s);
    endtask

    // pointer then one data byte; ok only when all three are acked
    task automatic write_reg(input logic [6:0] dev, input logic [7:0] ofs,
                             input logic [7:0] d, output logic ok);
        logic a0, a1, a2;
        start();
        send({dev, 1'b0}, a0);
        send(ofs, a1);
        send(d, a2);
        stop();
        ok = a0 & a1 & a2;
    endtask

    // pointer write, repeated start, single byte read
    task automatic read_reg(input logic [7:0] ofs, output logic [7:0] d);
        logic a;
        start();
        send({DEV_ADDR, 1'b0}, a);
        send(ofs, a);
        start();
        send({DEV_ADDR, 1'b1}, a);
        recv(1'b1, d);
        stop();
    endtask

    // read at the current pointer: two bytes, master acks the first
    task automatic read_two(output logic [7:0] d0, output logic [7:0] d1);
        logic a;
        start();
        send({DEV_ADDR, 1'b1}, a);
        recv(1'b0, d0);
        recv(1'b1, d1);
        stop();
    endtask
endmodule
`default_nettype wire

// ==== verification/monitor_warning_thresholds_tb.sv ====
// monitor_warning_thresholds_tb: self-checking bench for mwt_bank
// assumes mwt_host drives the serial pins and sda has a pull-up
`timescale 1ns/1ps
`default_nettype none
module monitor_warning_thresholds_tb
    import mwt_pkg::*;
();
    // low bytes set to all ones so any use of them in compares shows
    localparam logic [7:0] LIM_VAL [NUM_LIMITS] = '{
        8'h80, 8'hff, 8'h40, 8'hff, 8'h20,
        8'hff, 8'h10, 8'hff, 8'h30, 8'hff
    };

    logic       clk_sys, rst_n, scl, sda_pull, sda_wire;
    logic       sda_out, sda_oe, ok;
    logic       sup_upd, bias_upd, tx_upd;
    logic [7:0] sup_hi, bias_hi, tx_hi, rd, rd2;
    logic [4:0] warn;
    int         failures, cmp_count;

    // open-drain wire with pull-up
    assign sda_wire = ~(sda_pull | (sda_oe & ~sda_out));

    initial clk_sys = 1'b0;
    always #2.5 clk_sys = ~clk_sys;

    mwt_bank uut (
        .clk_sys           (clk_sys),
        .rst_n             (rst_n),
        .scl_in            (scl),
        .sda_in            (sda_wire),
        .sda_out           (sda_out),
        .sda_oe            (sda_oe),
        .supply_sample_upd (sup_upd),
        .supply_sample_hi  (sup_hi),
        .bias_sample_upd   (bias_upd),
        .bias_sample_hi    (bias_hi),
        .tx_sample_upd     (tx_upd),
        .tx_sample_hi      (tx_hi),
        .volt_high_warn    (warn[0]),
        .volt_low_warn     (warn[1]),
        .bias_high_warn    (warn[2]),
        .bias_low_warn     (warn[3]),
        .tx_high_warn      (warn[4])
    );

    mwt_host host (
        .clk_sys  (clk_sys),
        .sda_in   (sda_wire),
        .scl_out  (scl),
        .sda_pull (sda_pull)
    );

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic results();
        if (failures == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
        host.write_reg(DEV_ADDR, ofs, d, ok);
        check({7'h00, ok}, 8'h01);
    endtask

    task automatic rd_chk(input logic [7:0] ofs, input logic [7:0] exp);
        host.read_reg(ofs, rd);
        check(rd, exp);
    endtask

    // all channels see v, only ch is strobed: the others must not move
    task automatic sample(input int ch, input logic [7:0] v,
                          input logic [4:0] exp);
        sup_hi = v;
        bias_hi = v;
        tx_hi = v;
        {tx_upd, bias_upd, sup_upd} = 3'b001 << ch;
        @(posedge clk_sys);
        #1;
        {tx_upd, bias_upd, sup_upd} = 3'b000;
        @(posedge clk_sys);
        #1;
        check({3'h0, warn}, {3'h0, exp});
        rd_chk(OFS_STATUS, {3'h0, exp});
    endtask

    // watchdog: a hung run still reaches the verdict
    initial begin
        repeat (60000) @(posedge clk_sys);
        failures++;
        $display("ERROR %0t: run timed out", $time);
        results();
    end

    initial begin
        failures = 0;
        cmp_count = 0;
        rst_n = 1'b0;
        {sup_upd, bias_upd, tx_upd} = 3'b000;
        {sup_hi, bias_hi, tx_hi} = 24'h000000;
        repeat (10) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        check({3'h0, warn}, 8'h00);
        for (int i = 0; i < NUM_LIMITS; i++)
            rd_chk(LIMIT_OFS[i], LIMIT_RST);
        // foreign slave address must be ignored entirely
        host.write_reg(7'h52, LIMIT_OFS[IDX_VMIN_HI], 8'h77, ok);
        check({7'h00, ok}, 8'h00);
        rd_chk(LIMIT_OFS[IDX_VMIN_HI], 8'h00);
        for (int i = 0; i < NUM_LIMITS; i++)
            wr(LIMIT_OFS[i], LIM_VAL[i]);
        for (int i = 0; i < NUM_LIMITS; i++)
            rd_chk(LIMIT_OFS[i], LIM_VAL[i]);
        rd_chk(8'h20, RD_UNMAPPED);
        // current-pointer read of two bytes; master ack keeps it going
        rd_chk(LIMIT_OFS[IDX_BMAX_HI], LIM_VAL[IDX_BMAX_HI]);
        host.read_two(rd, rd2);
        check(rd, LIM_VAL[IDX_BMAX_LO]);
        check(rd2, LIM_VAL[IDX_BMIN_HI]);
        // strict compares at and just outside each limit
        sample(0, 8'h3f, 5'b00010);
        sample(0, 8'h40, 5'b00000);
        sample(0, 8'h81, 5'b00001);
        sample(0, 8'h80, 5'b00000);
        sample(1, 8'h21, 5'b00100);
        sample(1, 8'h20, 5'b00000);
        sample(1, 8'h0f, 5'b01000);
        sample(1, 8'h10, 5'b00000);
        sample(2, 8'h31, 5'b10000);
        sample(2, 8'h30, 5'b00000);
        sample(0, 8'h3f, 5'b00010);
        sample(1, 8'h21, 5'b00110);
        sample(2, 8'h31, 5'b10110);
        for (int i = IDX_VMAX_LO; i < NUM_LIMITS; i += 2)
            wr(LIMIT_OFS[i], 8'h00);
        // new limit alone must not move a flag until the next sample
        wr(LIMIT_OFS[IDX_VMIN_HI], 8'h00);
        check({3'h0, warn}, 8'h16);
        wr(OFS_STATUS, 8'hff);
        sample(0, 8'h3f, 5'b10100);
        // second reset in mid-run
        rst_n = 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        check({3'h0, warn}, 8'h00);
        rd_chk(LIMIT_OFS[IDX_BMIN_HI], LIMIT_RST);
        results();
    end
endmodule
`default_nettype wire
